// file: include/uvc_params.svh
`ifndef UVC_PARAMS_SVH
`define UVC_PARAMS_SVH

// ----------------------------------------
// setup packet encodings
// ----------------------------------------
`define UVC_REQTYPE_OUT 8'h40
`define UVC_REQTYPE_IN 8'hC0
`define UVC_BREQ_CONTROL 8'h01
`define UVC_ZERO_WORD 16'h0000

// ----------------------------------------
// selector codes carried in the value field
// ----------------------------------------
`define UVC_SEL_DEVICE_RESET 16'h0000
`define UVC_SEL_START_EXECUTION 16'h0001
`define UVC_SEL_RESUME_EXECUTION 16'h0002
`define UVC_SEL_HALT_ON_IDLE 16'h0003
`define UVC_SEL_HALT_ON_DONE 16'h0004
`define UVC_SEL_CANCEL_COMMAND 16'h0005
`define UVC_SEL_CANCEL_MACRO 16'h0006
`define UVC_SEL_FLUSH_COMMAND_FIFO 16'h0007
`define UVC_SEL_FLUSH_RECEIVE_BUFFER 16'h0008
`define UVC_SEL_FLUSH_TRANSMIT_BUFFER 16'h0009
`define UVC_SEL_READ_COMMAND_FIFO 16'h000A

// ----------------------------------------
// reset values
// ----------------------------------------
`define UVC_RST_BYTE 8'h00
`define UVC_RST_WORD 16'h0000

`endif

// file: include/uvc_pkg.sv
package uvc_pkg;

  typedef enum logic [3:0] {
    sel_none,
    sel_device_reset,
    sel_start_execution,
    sel_resume_execution,
    sel_halt_on_idle,
    sel_halt_on_done,
    sel_cancel_command,
    sel_cancel_macro,
    sel_flush_command_fifo,
    sel_flush_receive_buffer,
    sel_flush_transmit_buffer,
    sel_read_command_fifo
  } uvc_sel_t;

  // gray along run -> wait -> halted
  typedef enum logic [1:0] {
    hs_run = 2'h0,
    hs_wait_idle = 2'h1,
    hs_halted = 2'h3,
    hs_wait_done = 2'h2
  } uvc_halt_t;

  typedef enum logic [1:0] {
    rd_idle = 2'h0,
    rd_fetch = 2'h1,
    rd_show = 2'h3
  } uvc_rd_t;

endpackage : uvc_pkg

// file: include/uvc_sel_if.sv
`timescale 1ns/1ns
interface uvc_sel_if;
  uvc_pkg::uvc_sel_t sel;
  logic shape_ok;
  modport dec (output sel, output shape_ok);
  modport core (input sel, input shape_ok);
endinterface : uvc_sel_if

// file: hdl/uvc_setup_decode.sv
`timescale 1ns/1ns
`include "uvc_params.svh"
module uvc_setup_decode (
  // setup fields
  input wire logic [7:0] bm_request_type,
  input wire logic [7:0] b_request,
  input wire logic [15:0] w_value,
  input wire logic [15:0] w_index,
  input wire logic [15:0] w_length,
  // decoded result
  uvc_sel_if.dec sel_bus
);

  function automatic uvc_pkg::uvc_sel_t sel_of(input logic [15:0] code);
    case (code)
      `UVC_SEL_DEVICE_RESET: sel_of = uvc_pkg::sel_device_reset;
      `UVC_SEL_START_EXECUTION: sel_of = uvc_pkg::sel_start_execution;
      `UVC_SEL_RESUME_EXECUTION: sel_of = uvc_pkg::sel_resume_execution;
      `UVC_SEL_HALT_ON_IDLE: sel_of = uvc_pkg::sel_halt_on_idle;
      `UVC_SEL_HALT_ON_DONE: sel_of = uvc_pkg::sel_halt_on_done;
      `UVC_SEL_CANCEL_COMMAND: sel_of = uvc_pkg::sel_cancel_command;
      `UVC_SEL_CANCEL_MACRO: sel_of = uvc_pkg::sel_cancel_macro;
      `UVC_SEL_FLUSH_COMMAND_FIFO: sel_of = uvc_pkg::sel_flush_command_fifo;
      `UVC_SEL_FLUSH_RECEIVE_BUFFER: sel_of = uvc_pkg::sel_flush_receive_buffer;
      `UVC_SEL_FLUSH_TRANSMIT_BUFFER: sel_of = uvc_pkg::sel_flush_transmit_buffer;
      `UVC_SEL_READ_COMMAND_FIFO: sel_of = uvc_pkg::sel_read_command_fifo;
      default: sel_of = uvc_pkg::sel_none;
    endcase
  endfunction : sel_of

  uvc_pkg::uvc_sel_t sel;
  logic common_ok;

  assign sel = sel_of(w_value);
  assign common_ok = (b_request == `UVC_BREQ_CONTROL) && (w_index == `UVC_ZERO_WORD);
  assign sel_bus.sel = sel;

  // in-request for read-back, zero-length out-request for the rest
  always_comb begin
    if (sel == uvc_pkg::sel_read_command_fifo) begin
      sel_bus.shape_ok = common_ok && (bm_request_type == `UVC_REQTYPE_IN);
    end else begin
      sel_bus.shape_ok = common_ok && (sel != uvc_pkg::sel_none)
        && (bm_request_type == `UVC_REQTYPE_OUT) && (w_length == `UVC_ZERO_WORD);
    end
  end

endmodule : uvc_setup_decode

// file: hdl/uvc_ctrl_decoder.sv
`timescale 1ns/1ns
`include "uvc_params.svh"
module uvc_ctrl_decoder #(
  parameter int LEN_W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // setup packet from the usb endpoint 0 logic
  input wire logic setup_valid,
  input wire logic [7:0] bm_request_type,
  input wire logic [7:0] b_request,
  input wire logic [15:0] w_value,
  input wire logic [15:0] w_index,
  input wire logic [15:0] w_length,
  // answer to the setup packet
  output logic req_ack,
  output logic req_stall,
  // read-back data stage
  output logic [LEN_W-1:0] in_length,
  output logic in_valid,
  output logic [7:0] in_data,
  input wire logic in_ready,
  output logic in_done,
  // command fifo peek port
  input wire logic [LEN_W-1:0] fifo_count,
  output logic [LEN_W-1:0] fifo_peek_addr,
  input wire logic [7:0] fifo_peek_data,
  // execution engine
  input wire logic engine_idle,
  input wire logic engine_cmd_done,
  output logic halt_request,
  output logic halted,
  output logic device_reset,
  output logic start_execution,
  output logic resume_execution,
  output logic cancel_command,
  output logic cancel_macro,
  output logic flush_command_fifo,
  output logic flush_receive_buffer,
  output logic flush_transmit_buffer
);

  if (LEN_W < 8 || LEN_W > 16) begin : g_len_check
    $error("uvc_ctrl_decoder: LEN_W must be 8..16");
  end

  // ----------------------------------------
  // setup decode
  // ----------------------------------------
  uvc_sel_if sel_bus ();

  uvc_setup_decode u_decode (
    .bm_request_type(bm_request_type),
    .b_request(b_request),
    .w_value(w_value),
    .w_index(w_index),
    .w_length(w_length),
    .sel_bus(sel_bus)
  );

  function automatic logic needs_halt(input uvc_pkg::uvc_sel_t s);
    needs_halt = (s == uvc_pkg::sel_flush_command_fifo)
      || (s == uvc_pkg::sel_flush_receive_buffer)
      || (s == uvc_pkg::sel_flush_transmit_buffer)
      || (s == uvc_pkg::sel_read_command_fifo);
  endfunction : needs_halt

  uvc_pkg::uvc_halt_t halt_reg;
  uvc_pkg::uvc_rd_t rd_reg;
  logic accept;
  logic [LEN_W-1:0] idx_reg;

  assign halted = (halt_reg == uvc_pkg::hs_halted);
  assign halt_request = (halt_reg != uvc_pkg::hs_run);
  // halt-gated selectors refused while running
  assign accept = setup_valid && sel_bus.shape_ok
    && (!needs_halt(sel_bus.sel) || halted);

  // ----------------------------------------
  // answer
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      req_ack <= 1'b0;
      req_stall <= 1'b0;
    end else begin
      req_ack <= accept;
      req_stall <= setup_valid && !accept;
    end
  end

  // ----------------------------------------
  // halt state
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      halt_reg <= uvc_pkg::hs_run;
    end else if (accept && !halted && (sel_bus.sel == uvc_pkg::sel_halt_on_idle)) begin
      halt_reg <= uvc_pkg::hs_wait_idle;
    end else if (accept && !halted && (sel_bus.sel == uvc_pkg::sel_halt_on_done)) begin
      halt_reg <= uvc_pkg::hs_wait_done;
    end else if (accept && ((sel_bus.sel == uvc_pkg::sel_device_reset)
        || (sel_bus.sel == uvc_pkg::sel_start_execution)
        || (sel_bus.sel == uvc_pkg::sel_resume_execution))) begin
      halt_reg <= uvc_pkg::hs_run;
    end else begin
      // other accepted selectors must not swallow a done pulse
      unique case (halt_reg)
        uvc_pkg::hs_wait_idle: begin
          if (engine_idle) halt_reg <= uvc_pkg::hs_halted;
        end
        uvc_pkg::hs_wait_done: begin
          if (engine_cmd_done || engine_idle) halt_reg <= uvc_pkg::hs_halted;
        end
        uvc_pkg::hs_run,
        uvc_pkg::hs_halted: begin
          halt_reg <= halt_reg;
        end
      endcase
    end
  end

  // ----------------------------------------
  // command pulses to the engine
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      device_reset <= 1'b0;
      start_execution <= 1'b0;
      resume_execution <= 1'b0;
      cancel_command <= 1'b0;
      cancel_macro <= 1'b0;
    end else begin
      device_reset <= accept && (sel_bus.sel == uvc_pkg::sel_device_reset);
      start_execution <= accept && (sel_bus.sel == uvc_pkg::sel_start_execution);
      resume_execution <= accept && (sel_bus.sel == uvc_pkg::sel_resume_execution);
      cancel_command <= accept && (sel_bus.sel == uvc_pkg::sel_cancel_command);
      cancel_macro <= accept && (sel_bus.sel == uvc_pkg::sel_cancel_macro);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flush_command_fifo <= 1'b0;
      flush_receive_buffer <= 1'b0;
      flush_transmit_buffer <= 1'b0;
    end else begin
      flush_command_fifo <= accept && (sel_bus.sel == uvc_pkg::sel_flush_command_fifo);
      flush_receive_buffer <= accept
        && (sel_bus.sel == uvc_pkg::sel_flush_receive_buffer);
      flush_transmit_buffer <= accept
        && (sel_bus.sel == uvc_pkg::sel_flush_transmit_buffer);
    end
  end

  // ----------------------------------------
  // read-back data stage
  // ----------------------------------------
  assign in_valid = (rd_reg == uvc_pkg::rd_show);
  assign fifo_peek_addr = idx_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_reg <= uvc_pkg::rd_idle;
      idx_reg <= '0;
      in_length <= '0;
      in_data <= `UVC_RST_BYTE;
      in_done <= 1'b0;
    end else begin
      in_done <= 1'b0;
      if (accept && (sel_bus.sel == uvc_pkg::sel_read_command_fifo)) begin
        in_length <= fifo_count;
        idx_reg <= '0;
        if (fifo_count == '0) begin
          rd_reg <= uvc_pkg::rd_idle;
          in_done <= 1'b1;
        end else begin
          rd_reg <= uvc_pkg::rd_fetch;
        end
      end else if (setup_valid) begin
        // a new setup aborts any read-back in flight
        rd_reg <= uvc_pkg::rd_idle;
      end else begin
        unique case (rd_reg)
          uvc_pkg::rd_idle: begin
            rd_reg <= uvc_pkg::rd_idle;
          end
          uvc_pkg::rd_fetch: begin
            in_data <= fifo_peek_data;
            rd_reg <= uvc_pkg::rd_show;
          end
          uvc_pkg::rd_show: begin
            if (in_ready) begin
              if (idx_reg + LEN_W'(1) == in_length) begin
                rd_reg <= uvc_pkg::rd_idle;
                in_done <= 1'b1;
              end else begin
                idx_reg <= idx_reg + LEN_W'(1);
                rd_reg <= uvc_pkg::rd_fetch;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_halt_idle;
    @(posedge clock) disable iff (!resetn)
      (halt_reg == uvc_pkg::hs_wait_idle) && engine_idle && !setup_valid |=> halted;
  endproperty
  a_halt_idle: assert property (p_halt_idle) else $error("halt on idle missed");

  property p_halt_done;
    @(posedge clock) disable iff (!resetn)
      (halt_reg == uvc_pkg::hs_wait_done) && engine_cmd_done && !setup_valid |=> halted;
  endproperty
  a_halt_done: assert property (p_halt_done) else $error("halt on done missed");

  property p_flush_cmd;
    @(posedge clock) disable iff (!resetn)
      flush_command_fifo |-> $past(halted) && $past(setup_valid);
  endproperty
  a_flush_cmd: assert property (p_flush_cmd) else $error("fifo flush while running");

  property p_flush_rx;
    @(posedge clock) disable iff (!resetn)
      (setup_valid && sel_bus.sel == uvc_pkg::sel_flush_receive_buffer && !halted)
      |=> req_stall && !flush_receive_buffer;
  endproperty
  a_flush_rx: assert property (p_flush_rx) else $error("rx flush while running");

  property p_flush_tx;
    @(posedge clock) disable iff (!resetn)
      flush_transmit_buffer |-> $past(halted) && req_ack;
  endproperty
  a_flush_tx: assert property (p_flush_tx) else $error("tx flush while running");

  property p_read_gate;
    @(posedge clock) disable iff (!resetn)
      (setup_valid && sel_bus.sel == uvc_pkg::sel_read_command_fifo && !halted)
      |=> req_stall && !req_ack && !in_valid;
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("read-back while running");

  property p_read_len;
    @(posedge clock) disable iff (!resetn)
      (accept && sel_bus.sel == uvc_pkg::sel_read_command_fifo && fifo_count != '0)
      ##1 !setup_valid |-> (in_length == $past(fifo_count)) && !in_valid ##1 in_valid;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read-back length wrong");

  property p_zero_len;
    @(posedge clock) disable iff (!resetn)
      (setup_valid && sel_bus.sel == uvc_pkg::sel_start_execution && w_length != '0)
      |=> req_stall && !start_execution;
  endproperty
  a_zero_len: assert property (p_zero_len) else $error("nonzero length accepted");

endmodule : uvc_ctrl_decoder

// file: bench/uvc_fifo_model.sv
`timescale 1ns/1ns
module uvc_fifo_model #(
  parameter int LEN_W = 16
) (
  // peek port
  input wire logic [LEN_W-1:0] fifo_count,
  input wire logic [LEN_W-1:0] fifo_peek_addr,
  output logic [7:0] fifo_peek_data
);
  // ----------------------------------------
  // byte store
  // ----------------------------------------
  // held bytes carry a pattern, others its inverse
  assign fifo_peek_data = (fifo_peek_addr < fifo_count) ? (8'h5A ^ fifo_peek_addr[7:0]) :
    (8'hA5 ^ fifo_peek_addr[7:0]);
endmodule : uvc_fifo_model

// file: bench/tb_uvc_ctrl_decoder.sv
`timescale 1ns/1ns
module tb_uvc_ctrl_decoder;
  typedef struct packed {
    logic [7:0] t;
    logic [7:0] r;
    logic [15:0] v;
    logic [15:0] i;
    logic [15:0] l;
    logic ack;
    logic [7:0] pul;
  } uvc_row_t;

  logic clock = 1'b0;
  logic resetn, setup_valid, in_ready, engine_idle, engine_cmd_done;
  logic [7:0] bm_request_type, b_request, in_data, fifo_peek_data, pulses;
  logic [15:0] w_value, w_index, w_length, in_length, fifo_count, fifo_peek_addr;
  logic req_ack, req_stall, in_valid, in_done, halt_request, halted;
  logic device_reset, start_execution, resume_execution, cancel_command, cancel_macro;
  logic flush_command_fifo, flush_receive_buffer, flush_transmit_buffer;
  int num_errors = 0;
  int total_checks = 0;

  // ----------------------------------------
  // rows: type, request, value, index, length, ack, pulses
  // ----------------------------------------
  uvc_row_t rows [17] = '{
    '{8'h40, 8'h01, 16'h0007, 16'h0000, 16'h0000, 1'b1, 8'h04},
    '{8'h40, 8'h01, 16'h0008, 16'h0000, 16'h0000, 1'b1, 8'h02},
    '{8'h40, 8'h01, 16'h0009, 16'h0000, 16'h0000, 1'b1, 8'h01},
    '{8'h40, 8'h01, 16'h0007, 16'h0001, 16'h0000, 1'b0, 8'h00},
    '{8'h40, 8'h01, 16'h0007, 16'h0000, 16'h0001, 1'b0, 8'h00},
    '{8'hC0, 8'h01, 16'h0007, 16'h0000, 16'h0000, 1'b0, 8'h00},
    '{8'h40, 8'h02, 16'h0005, 16'h0000, 16'h0000, 1'b0, 8'h00},
    '{8'h40, 8'h01, 16'h0003, 16'h0000, 16'h0000, 1'b1, 8'h00},
    '{8'h40, 8'h01, 16'h0004, 16'h0000, 16'h0000, 1'b1, 8'h00},
    '{8'h40, 8'h01, 16'h0005, 16'h0000, 16'h0000, 1'b1, 8'h10},
    '{8'h40, 8'h01, 16'h0006, 16'h0000, 16'h0000, 1'b1, 8'h08},
    '{8'h40, 8'h01, 16'h000B, 16'h0000, 16'h0000, 1'b0, 8'h00},
    '{8'h40, 8'h01, 16'h0001, 16'h0000, 16'h0000, 1'b1, 8'h40},
    '{8'h40, 8'h01, 16'h0008, 16'h0000, 16'h0000, 1'b0, 8'h00},
    '{8'hC0, 8'h01, 16'h000A, 16'h0000, 16'h0000, 1'b0, 8'h00},
    '{8'h40, 8'h01, 16'h0002, 16'h0000, 16'h0000, 1'b1, 8'h20},
    '{8'h40, 8'h01, 16'h0000, 16'h0000, 16'h0000, 1'b1, 8'h80}
  };

  assign pulses = {device_reset, start_execution, resume_execution, cancel_command,
    cancel_macro, flush_command_fifo, flush_receive_buffer, flush_transmit_buffer};

  always #5 clock = ~clock;

  uvc_ctrl_decoder #(.LEN_W(16)) dut (
    .clock(clock), .resetn(resetn), .setup_valid(setup_valid),
    .bm_request_type(bm_request_type), .b_request(b_request), .w_value(w_value),
    .w_index(w_index), .w_length(w_length), .req_ack(req_ack), .req_stall(req_stall),
    .in_length(in_length), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .in_done(in_done), .fifo_count(fifo_count), .fifo_peek_addr(fifo_peek_addr),
    .fifo_peek_data(fifo_peek_data), .engine_idle(engine_idle),
    .engine_cmd_done(engine_cmd_done), .halt_request(halt_request), .halted(halted),
    .device_reset(device_reset), .start_execution(start_execution),
    .resume_execution(resume_execution), .cancel_command(cancel_command),
    .cancel_macro(cancel_macro), .flush_command_fifo(flush_command_fifo),
    .flush_receive_buffer(flush_receive_buffer), .flush_transmit_buffer(flush_transmit_buffer)
  );

  uvc_fifo_model #(.LEN_W(16)) fifo (
    .fifo_count(fifo_count), .fifo_peek_addr(fifo_peek_addr), .fifo_peek_data(fifo_peek_data)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic send(input logic [7:0] t, r, input logic [15:0] v, i, l);
    @(negedge clock);
    setup_valid = 1'b1;
    bm_request_type = t;
    b_request = r;
    w_value = v;
    w_index = i;
    w_length = l;
    @(negedge clock);
    setup_valid = 1'b0;
  endtask : send

  task automatic readback(input logic [15:0] cnt);
    int k;
    fifo_count = cnt;
    send(8'hC0, 8'h01, 16'h000A, 16'h0000, 16'h0040);
    chk(req_ack, 1'b1, "read ack");
    chk(in_length, cnt, "read length");
    for (int b = 0; b < cnt; b++) begin
      k = 0;
      while (in_valid !== 1'b1 && k < 10) begin
        @(negedge clock);
        k++;
      end
      chk(in_data, 8'h5A ^ b[7:0], "read byte");
      @(negedge clock);
    end
    chk(in_done, 1'b1, "read done");
    chk(in_valid, 1'b0, "read valid");
    $display("test readback of %0d bytes done", cnt);
  endtask : readback

  task automatic conclude;
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {resetn, setup_valid, engine_idle, engine_cmd_done} = 4'h0;
    {bm_request_type, b_request, w_value, w_index, w_length} = 64'h0;
    in_ready = 1'b1;
    fifo_count = 16'h0000;
    repeat (4) @(negedge clock);
    chk(pulses, 8'h00, "reset pulses");
    chk({halted, halt_request, in_valid}, 3'h0, "reset state");
    chk(in_length, 16'h0000, "reset length");
    resetn = 1'b1;
    $display("test reset done");
    send(8'h40, 8'h01, 16'h0003, 16'h0000, 16'h0000);
    chk({req_ack, halt_request, halted}, 3'h6, "halt idle ack");
    @(negedge clock);
    chk(halted, 1'b0, "halt while busy");
    engine_idle = 1'b1;
    @(negedge clock);
    chk(halted, 1'b1, "halt once idle");
    engine_idle = 1'b0;
    $display("test halt on idle done");
    for (int n = 0; n < 17; n++) begin
      send(rows[n].t, rows[n].r, rows[n].v, rows[n].i, rows[n].l);
      chk(req_ack, rows[n].ack, "row ack");
      chk(req_stall, !rows[n].ack, "row stall");
      chk(pulses, rows[n].pul, "row pulses");
    end
    $display("test table done");
    send(8'h40, 8'h01, 16'h0004, 16'h0000, 16'h0000);
    @(negedge clock);
    chk(halted, 1'b0, "halt before done");
    engine_cmd_done = 1'b1;
    @(negedge clock);
    engine_cmd_done = 1'b0;
    chk(halted, 1'b1, "halt after done");
    $display("test halt on done done");
    readback(16'h0003);
    readback(16'h0000);
    fifo_count = 16'h0002;
    send(8'hC0, 8'h01, 16'h000A, 16'h0000, 16'h0000);
    send(8'h40, 8'h01, 16'h0009, 16'h0000, 16'h0000);
    chk({in_valid, in_done, flush_transmit_buffer}, 3'h1, "read abort");
    $display("test readback abort done");
    resetn = 1'b0;
    #1;
    chk({halted, halt_request, in_length[13:0]}, 16'h0000, "mid-run reset");
    @(negedge clock);
    resetn = 1'b1;
    send(8'h40, 8'h01, 16'h0001, 16'h0000, 16'h0000);
    chk(pulses, 8'h40, "start after reset");
    chk(req_ack, 1'b1, "ack after reset");
    $display("test mid-run reset done");
    conclude;
  end

  initial begin
    #20000;
    num_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    conclude;
  end
endmodule : tb_uvc_ctrl_decoder
